// ==== hw/acps_pkg.sv ====
// Shared constants and carrier types for the ASCII parameter command server
package acps_pkg;
	// ASCII characters used on the command line
	localparam logic [7:0] ASCII_CR = 8'h0D;
	localparam logic [7:0] ASCII_LF = 8'h0A;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] ASCII_NINE = 8'h39;
	localparam logic [7:0] ASCII_A_UP = 8'h41;
	localparam logic [7:0] ASCII_F_UP = 8'h46;
	localparam logic [7:0] ASCII_A_LO = 8'h61;
	localparam logic [7:0] ASCII_F_LO = 8'h66;
	localparam logic [3:0] HEX_LETTER_BIAS = 4'h9;
	localparam logic [3:0] HEX_DIGIT_LIMIT = 4'hA;

	// Command letters
	localparam logic [7:0] CMD_READ = 8'h52;
	localparam logic [7:0] CMD_WRITE = 8'h57;
	localparam logic [7:0] CMD_IDENT = 8'h49;
	localparam logic [7:0] CMD_ENDIAN = 8'h4D;

	// Endian mode answers
	localparam logic [7:0] ENDIAN_BIG = 8'h00;
	localparam logic [7:0] ENDIAN_LITTLE = 8'h01;

	// Default listening port, 6668 decimal
	localparam logic [15:0] TCP_PORT = 16'h1A0C;

	// Parameter field sizes and limits
	localparam logic [7:0] OBJ_MAX_LEN = 8'h04;
	localparam logic [4:0] HDR_NIBBLES = 5'h08;
	localparam logic [4:0] MAX_NIBBLES = 5'h10;
	localparam int IDENT_MAX = 15;
	localparam int PAY_BYTES = 16;
	localparam int REPLY_BYTES = 18;

	// Error codes sent in front of each reply
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_BAD_CMD = 16'h0001;
	localparam logic [15:0] ERR_BAD_HEX = 16'h0002;
	localparam logic [15:0] ERR_BAD_LEN = 16'h0003;

	// Object dictionary request
	typedef struct packed {
		logic write;
		logic [15:0] index;
		logic [7:0] subIndex;
		logic [7:0] length;
		logic [31:0] wdata;
	} acps_obj_req_t;

	// Object dictionary answer
	typedef struct packed {
		logic ack;
		logic [15:0] error;
		logic [31:0] rdata;
	} acps_obj_rsp_t;
endpackage

// ==== hw/acps_hex_tx.sv ====
// Byte to two-character ASCII hex serializer, with line-feed insertion
`timescale 1ns/10ps
module acps_hex_tx (
	input logic mclk,
	input logic nrst,
	input logic inValid,
	input logic [7:0] inByte,
	input logic inLf,
	output logic inReady,
	output logic txValid,
	output logic [7:0] txData,
	input logic txReady
);
	import acps_pkg::*;

	logic busyReg;
	logic lowPendReg;
	logic [3:0] lowNibReg;
	logic [7:0] charReg;
	logic take;
	logic sent;

	// Nibble to upper-case ASCII hex character
	function automatic logic [7:0] toAscii(input logic [3:0] nib);
		logic [7:0] res;
		res = (nib < HEX_DIGIT_LIMIT) ? (ASCII_ZERO + {4'h0, nib})
			: (ASCII_A_UP + {4'h0, nib - HEX_DIGIT_LIMIT});
		return res;
	endfunction

	// Handshakes
	assign inReady = ~busyReg;
	assign take = inValid & inReady;
	assign sent = busyReg & txReady;
	assign txValid = busyReg;
	assign txData = charReg;

	// High nibble first, then low nibble, or a lone line feed
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busyReg <= 1'b0;
			lowPendReg <= 1'b0;
			lowNibReg <= 4'h0;
			charReg <= 8'h00;
		end else if (take) begin
			busyReg <= 1'b1;
			charReg <= inLf ? ASCII_LF : toAscii(inByte[7:4]);
			lowPendReg <= ~inLf;
			lowNibReg <= inByte[3:0];
		end else if (sent) begin
			if (lowPendReg) begin
				charReg <= toAscii(lowNibReg);
				lowPendReg <= 1'b0;
			end else begin
				busyReg <= 1'b0;
			end
		end
	end
endmodule // acps_hex_tx

// ==== hw/acps_server.sv ====
// ASCII hex command interpreter: parses command lines, answers in hex
`timescale 1ns/10ps
module acps_server #(
	parameter logic [3:0] IDENT_LEN = 4'h5, // Arbitrary identify text length
	parameter logic [119:0] IDENT_TEXT = 120'h4F_5652_4553 // Arbitrary text, first char low
) (
	input logic mclk,
	input logic nrst,
	input logic rxValid,
	input logic [7:0] rxData,
	output logic rxReady,
	output logic txValid,
	output logic [7:0] txData,
	input logic txReady,
	output logic objReqValid,
	output acps_pkg::acps_obj_req_t objReq,
	input acps_pkg::acps_obj_rsp_t objRsp,
	output logic [15:0] listenPort
);
	import acps_pkg::*;

	typedef enum logic [1:0] {
		S_COLLECT = 2'b00,
		S_ACCESS = 2'b01,
		S_REPLY = 2'b11,
		S_TERM = 2'b10
	} acps_state_t;

	acps_state_t state_reg, state_next;
	logic [7:0] cmd_reg;
	logic haveCmd_reg;
	logic [31:0] hdr_reg;
	logic [31:0] dat_reg;
	logic [4:0] cnt_reg;
	logic bad_reg;
	logic ovf_reg;
	logic reqValid_reg;
	acps_obj_req_t req_reg;
	logic [7:0] buf_reg [REPLY_BYTES];
	logic [7:0] bufNext [REPLY_BYTES];
	logic [7:0] pay [PAY_BYTES];
	logic [4:0] idx_reg;
	logic [4:0] total_reg;

	logic rxTake, isCr, isLf, isDigit, isUpper, isLower, isHexCh;
	logic [3:0] nibVal;
	logic lineEnd;
	logic cmdR, cmdW, cmdI, cmdM, cmdKnown;
	logic [7:0] hdrLen;
	logic lenOk;
	logic [4:0] wCnt;
	logic [15:0] decErr;
	logic needAccess;
	logic [31:0] datAligned;
	logic [31:0] wdataLe;
	logic loadDirect, loadAccess, load;
	logic identLd, modeLd, readLd;
	logic [15:0] loadErr;
	logic [4:0] payLen;
	logic hexValid, hexLf, hexReady;
	logic [7:0] hexByte;
	logic lastByte;

	// Receive character classes
	assign rxReady = (state_reg == S_COLLECT);
	assign rxTake = rxValid & rxReady;
	assign isCr = (rxData == ASCII_CR);
	assign isLf = (rxData == ASCII_LF);
	assign isDigit = (rxData >= ASCII_ZERO) && (rxData <= ASCII_NINE);
	assign isUpper = (rxData >= ASCII_A_UP) && (rxData <= ASCII_F_UP);
	assign isLower = (rxData >= ASCII_A_LO) && (rxData <= ASCII_F_LO);
	assign isHexCh = isDigit | isUpper | isLower;
	assign nibVal = isDigit ? rxData[3:0] : (rxData[3:0] + HEX_LETTER_BIAS);
	assign lineEnd = rxTake & isCr;

	// Parse letter and hex nibbles; LF after CR is simply dropped
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg <= 8'h00;
			haveCmd_reg <= 1'b0;
			hdr_reg <= 32'h0000_0000;
			dat_reg <= 32'h0000_0000;
			cnt_reg <= 5'h00;
			bad_reg <= 1'b0;
			ovf_reg <= 1'b0;
		end else if (lineEnd) begin
			haveCmd_reg <= 1'b0;
			cnt_reg <= 5'h00;
			bad_reg <= 1'b0;
			ovf_reg <= 1'b0;
		end else if (rxTake && !isLf) begin
			if (!haveCmd_reg) begin
				cmd_reg <= rxData;
				haveCmd_reg <= 1'b1;
			end else if (!isHexCh) begin
				bad_reg <= 1'b1;
			end else if (cnt_reg == MAX_NIBBLES) begin
				ovf_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 5'h01;
				// Header nibbles first, MSB first
				if (cnt_reg < HDR_NIBBLES) begin
					hdr_reg <= {hdr_reg[27:0], nibVal};
				end else begin
					dat_reg <= {dat_reg[27:0], nibVal};
				end
			end
		end
	end

	// Command decode and validity
	assign cmdR = (cmd_reg == CMD_READ);
	assign cmdW = (cmd_reg == CMD_WRITE);
	assign cmdI = (cmd_reg == CMD_IDENT);
	assign cmdM = (cmd_reg == CMD_ENDIAN);
	assign cmdKnown = cmdR | cmdW | cmdI | cmdM;
	assign hdrLen = hdr_reg[7:0];
	assign lenOk = (hdrLen != 8'h00) && (hdrLen <= OBJ_MAX_LEN);
	assign wCnt = HDR_NIBBLES + {hdrLen[3:0], 1'b0};
	// Error selection
	assign decErr = (!haveCmd_reg || !cmdKnown) ? ERR_BAD_CMD
		: (bad_reg || ovf_reg) ? ERR_BAD_HEX
		: (cmdR && cnt_reg != HDR_NIBBLES) ? ERR_BAD_HEX
		: (cmdR && !lenOk) ? ERR_BAD_LEN
		: (cmdW && cnt_reg < HDR_NIBBLES) ? ERR_BAD_HEX
		: (cmdW && (!lenOk || cnt_reg != wCnt)) ? ERR_BAD_LEN
		: ((cmdI || cmdM) && cnt_reg != 5'h00) ? ERR_BAD_HEX
		: ERR_NONE;
	assign needAccess = (decErr == ERR_NONE) && (cmdR || cmdW);

	// Write data arrives lowest byte first
	assign datAligned = dat_reg << {3'd4 - hdrLen[2:0], 3'b000};
	genvar j;
	generate
		for (j = 0; j < 4; j++) begin : g_wbyte
			assign wdataLe[8*j +: 8] = (hdrLen[2:0] > 3'(j)) ? datAligned[31-8*j -: 8] : 8'h00;
		end
	endgenerate

	// Object request held until acknowledged
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reqValid_reg <= 1'b0;
			req_reg <= '0;
		end else if (lineEnd && needAccess) begin
			reqValid_reg <= 1'b1;
			req_reg <= '{write: cmdW, index: hdr_reg[31:16], subIndex: hdr_reg[15:8],
				length: hdrLen, wdata: wdataLe};
		end else if (objRsp.ack) begin
			reqValid_reg <= 1'b0;
		end
	end
	assign objReqValid = reqValid_reg;
	assign objReq = req_reg;

	// Reply contents at load time
	assign loadDirect = lineEnd & ~needAccess;
	assign loadAccess = (state_reg == S_ACCESS) & objRsp.ack;
	assign load = loadDirect | loadAccess;
	assign identLd = loadDirect && (decErr == ERR_NONE) && cmdI;
	assign modeLd = loadDirect && (decErr == ERR_NONE) && cmdM;
	// Data only on a clean read
	assign readLd = loadAccess && !req_reg.write && (objRsp.error == ERR_NONE);
	assign loadErr = loadAccess ? objRsp.error : decErr;
	assign payLen = identLd ? ({1'b0, IDENT_LEN} + 5'h01)
		: modeLd ? 5'h01
		: readLd ? req_reg.length[4:0]
		: 5'h00;

	// Payload and reply buffer, one entry per byte
	genvar k;
	generate
		for (k = 0; k < PAY_BYTES; k++) begin : g_pay
			if (k == 0) begin : g_first
				// Length byte, endian byte or lowest read data byte
				assign pay[k] = identLd ? {4'h0, IDENT_LEN}
					: modeLd ? ENDIAN_LITTLE
					: readLd ? objRsp.rdata[7:0] : 8'h00;
			end else if (k < 4) begin : g_data
				assign pay[k] = identLd ? IDENT_TEXT[8*(k-1) +: 8]
					: readLd ? objRsp.rdata[8*k +: 8] : 8'h00;
			end else begin : g_text
				assign pay[k] = identLd ? IDENT_TEXT[8*(k-1) +: 8] : 8'h00;
			end
		end
		for (k = 0; k < REPLY_BYTES; k++) begin : g_buf
			if (k == 0) begin : g_ehi
				assign bufNext[k] = loadErr[15:8];
			end else if (k == 1) begin : g_elo
				assign bufNext[k] = loadErr[7:0];
			end else begin : g_pl
				assign bufNext[k] = pay[k-2];
			end
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					buf_reg[k] <= 8'h00;
				end else if (load) begin
					buf_reg[k] <= bufNext[k];
				end
			end
		end
	endgenerate

	// Reply length and send position
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			total_reg <= 5'h00;
			idx_reg <= 5'h00;
		end else if (load) begin
			total_reg <= payLen + 5'h02;
			idx_reg <= 5'h00;
		end else if (state_reg == S_REPLY && hexReady) begin
			idx_reg <= idx_reg + 5'h01;
		end
	end

	// Feed serializer; line feed alone closes the reply
	assign lastByte = (idx_reg == total_reg - 5'h01);
	assign hexValid = (state_reg == S_REPLY) || (state_reg == S_TERM);
	assign hexLf = (state_reg == S_TERM);
	assign hexByte = buf_reg[idx_reg];

	// Sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_COLLECT: begin
				if (lineEnd) begin
					state_next = needAccess ? S_ACCESS : S_REPLY;
				end
			end
			S_ACCESS: begin
				if (objRsp.ack) begin
					state_next = S_REPLY;
				end
			end
			S_REPLY: begin
				if (hexReady && lastByte) begin
					state_next = S_TERM;
				end
			end
			S_TERM: begin
				if (hexReady) begin
					state_next = S_COLLECT;
				end
			end
			default: begin
				state_next = S_COLLECT;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= S_COLLECT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Hex character serializer
	acps_hex_tx u_hex_tx (
		.mclk(mclk),
		.nrst(nrst),
		.inValid(hexValid),
		.inByte(hexByte),
		.inLf(hexLf),
		.inReady(hexReady),
		.txValid(txValid),
		.txData(txData),
		.txReady(txReady)
	);

	// Port number for the connection layer
	assign listenPort = TCP_PORT;
endmodule // acps_server

// ==== verification/acps_server_assertions.sv ====
// Port checks for the command server
`timescale 1ns/10ps
module acps_server_assertions (
	input logic mclk,
	input logic nrst,
	input logic rxValid,
	input logic [7:0] rxData,
	input logic rxReady,
	input logic txValid,
	input logic [7:0] txData,
	input logic txReady,
	input logic objReqValid,
	input acps_pkg::acps_obj_req_t objReq,
	input acps_pkg::acps_obj_rsp_t objRsp,
	input logic [15:0] listenPort
);
	import acps_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// End of a command line
	wire crTaken = rxValid && rxReady && rxData == ASCII_CR;
	wire ackSeen = objReqValid && objRsp.ack;

	// Listen port value, reply framing and hold
	a_port_default: assert property (listenPort == TCP_PORT)
		else $error("listen port wrong");
	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply char dropped");
	a_hex_char: assert property (txValid |-> txData inside {[8'h30:8'h39], [8'h41:8'h46], 8'h0A})
		else $error("reply char not hex");
	a_no_cr: assert property (txValid |-> txData != ASCII_CR)
		else $error("carriage return in reply");
	a_lf_last: assert property (txValid && txReady && txData == ASCII_LF |=> !txValid)
		else $error("reply goes on after line feed");
	// Command and object access timing
	a_cr_answer: assert property (crTaken |-> ##[1:3] (objReqValid || txValid))
		else $error("no answer to command");
	a_req_hold: assert property (objReqValid && !objRsp.ack |=> objReqValid && $stable(objReq))
		else $error("object request changed");
	a_req_drop: assert property (ackSeen |=> !objReqValid ##[0:3] txValid)
		else $error("no reply after object answer");
	a_req_len: assert property (objReqValid |-> objReq.length inside {[8'h01:8'h04]})
		else $error("bad length reached store");
	c_read: cover property (ackSeen && !objReq.write);
	c_write: cover property (ackSeen && objReq.write);
	c_stall: cover property (txValid && !txReady);
endmodule // acps_server_assertions

bind acps_server acps_server_assertions u_chk (.mclk(mclk), .nrst(nrst), .rxValid(rxValid),
	.rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
	.objReqValid(objReqValid), .objReq(objReq), .objRsp(objRsp), .listenPort(listenPort));

// ==== verification/acps_client_model.sv ====
// Reply sink standing in for the commissioning client
`timescale 1ns/10ps
module acps_client_model (
	input logic mclk,
	input logic slow,
	input logic clear,
	input logic txValid,
	input logic [7:0] txData,
	output logic txReady,
	output logic [159:0] line,
	output logic lineDone
);
	import acps_pkg::*;
	initial txReady = 1'b1;
	// Accept every cycle, or every other one when slow
	always @(negedge mclk) begin
		txReady <= slow ? !txReady : 1'b1;
	end
	// Collect reply characters up to the lone line feed
	always @(posedge mclk) begin
		if (clear) begin
			line <= '0;
			lineDone <= 1'b0;
		end else if (txValid && txReady) begin
			line <= {line[151:0], txData};
			lineDone <= (txData == ASCII_LF);
		end
	end
endmodule // acps_client_model

// ==== verification/acps_server_tb_top.sv ====
// Testbench for the command server
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module acps_server_tb_top;
	import acps_pkg::*;
	logic mclk = 0, nrst = 0, rxValid = 0, slow = 0, clear = 0;
	logic [7:0] rxData = '0;
	logic rxReady, txValid, txReady, objReqValid, lineDone;
	logic [7:0] txData;
	logic [15:0] listenPort;
	logic [15:0] storeErr = '0;
	logic [159:0] line;
	acps_obj_req_t objReq, lastReq;
	acps_obj_rsp_t objRsp = '0;
	int fails = 0, checks = 0, lat = 0, waitN = 0;
	always #2.5 mclk = ~mclk;

	acps_server dut (.mclk(mclk), .nrst(nrst), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
		.objReqValid(objReqValid), .objReq(objReq), .objRsp(objRsp), .listenPort(listenPort));
	acps_client_model client (.mclk(mclk), .slow(slow), .clear(clear), .txValid(txValid),
		.txData(txData), .txReady(txReady), .line(line), .lineDone(lineDone));

	// Object store answering after a set wait
	always @(negedge mclk) begin
		objRsp.ack <= 1'b0;
		if (objReqValid && !objRsp.ack) begin
			if (waitN == lat) begin
				objRsp <= '{1'b1, storeErr, 32'h4433_2211};
				lastReq <= objReq;
				waitN <= 0;
			end else waitN <= waitN + 1;
		end
	end

	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Offer one character, held until taken
	task automatic put(input logic [7:0] c);
		int n;
		n = 0;
		rxValid = 1'b1;
		rxData = c;
		while (!rxReady && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 400) begin
			fails++;
			test_done();
		end
		@(negedge mclk);
	endtask

	// Send a full line, then wait for the reply line
	task automatic cmd(input string s);
		int n;
		n = 0;
		clear = 1'b1;
		@(negedge mclk);
		clear = 1'b0;
		foreach (s[i]) put(s[i]);
		put(ASCII_CR);
		put(ASCII_LF);
		rxValid = 1'b0;
		while (!lineDone && n < 400) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 400) begin
			fails++;
			test_done();
		end
	endtask

	task automatic t_endian();
		cmd("M");
		`CHK(line, "000001\n")
		`CHK(listenPort, TCP_PORT)
		$display("endian query done");
	endtask

	task automatic t_read();
		lat = 3;
		slow = 1'b1;
		cmd("R60410002");
		`CHK(lastReq.index, 16'h6041)
		`CHK({lastReq.write, lastReq.length}, 9'h002)
		`CHK(line, "00001122\n")
		slow = 1'b0;
		storeErr = 16'h0605;
		cmd("R60410004");
		`CHK(line, "0605\n")
		storeErr = 16'h0000;
		$display("read done");
	endtask

	task automatic t_write();
		lat = 0;
		cmd("W604000020f80");
		`CHK(lastReq.wdata[15:0], 16'h800F)
		`CHK(lastReq.write, 1'b1)
		`CHK(line, "0000\n")
		$display("write done");
	endtask

	task automatic t_ident();
		cmd("I");
		`CHK(line, "000005534552564F\n")
		$display("identify done");
	endtask

	task automatic t_bad();
		cmd("X");
		`CHK(line, "0001\n")
		cmd("");
		`CHK(line, "0001\n")
		cmd("RZZ00");
		`CHK(line, "0002\n")
		cmd("W6040000400000000F");
		`CHK(line, "0002\n")
		cmd("R60410005");
		`CHK(line, "0003\n")
		$display("bad commands done");
	endtask

	// Reset in the middle of a reply, then a clean command
	task automatic t_reset();
		put(CMD_ENDIAN);
		put(ASCII_CR);
		rxValid = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK(txValid, 1'b1)
		nrst = 1'b0;
		@(negedge mclk);
		`CHK({rxReady, txValid, objReqValid}, 3'b100)
		nrst = 1'b1;
		@(negedge mclk);
		cmd("M");
		`CHK(line, "000001\n")
		$display("reset mid reply done");
	endtask

	// Reset, then run every scenario
	initial begin
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		t_endian();
		t_read();
		t_write();
		t_ident();
		t_bad();
		t_reset();
		test_done();
	end
endmodule // acps_server_tb_top
